// ===== hw/ivc_core.v
// four-level vectored interrupt controller with apb register port
// assumes: core gives one-pclk machine-cycle strobe and instruction status
//
// Contract
// RULE1 - two bits give four levels, 11 highest
// RULE2 - only strictly higher level preempts running routine
// RULE3 - level three routine is never preempted
// RULE4 - equal level ties go by natural order
// RULE5 - vector is 0003h plus eight per source
// RULE6 - only externals, wake timer, brownout wake
// RULE7 - edge flag clears on vector; level tracks pin
// RULE8 - timer0/1 flags hardware cleared, timer2 kept
// RULE9 - sample, poll and resolve each machine cycle
// RULE10 - call needs free level, last cycle, no block
// RULE11 - blocked requests are never remembered
// RULE12 - call pushes pc only, then loads vector
// RULE13 - return ends service, plain return does not
// RULE14 - call lasts two machine cycles
// RULE15 - worst latency nine cycles without nesting
// RULE16 - global and individual enables gate requests
// RULE17 - shared vector requested by or of flags
// RULE18 - any set flag requests, hardware or software
// RULE19 - edge flag set on high then low sample
// RULE20 - one in-service marker per level
`timescale 1ns/1ps
`include "ivc_consts.vh"

module ivc_core
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire [3:0] ext_irq_pin_n,
	input wire tmr0_ovf_set,
	input wire tmr1_ovf_set,
	input wire tmr2_ovf_flag,
	input wire tmr2_ext_flag,
	input wire uart_rx_flag,
	input wire uart_tx_flag,
	input wire spi_done_flag,
	input wire spi_fault_flag,
	input wire spi_overrun_flag,
	input wire wake_timer_flag,
	input wire brownout_flag,
	input wire mc_strobe,
	input wire insn_last_cycle,
	input wire insn_blocks_irq,
	input wire irq_return,
	output reg call_active,
	output reg call_push_pc,
	output reg call_load_pc,
	output reg [15:0] vec_addr,
	output reg wake_req
);

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
// returns {valid, level, index}; descending scan so lower index wins ties
function [6:0] ivc_resolve;
	input [10:0] req;
	input [10:0] hi;
	input [10:0] lo;
	integer i;
	reg [1:0] lvl;
	begin
		ivc_resolve = 7'h00;
		for (i = 10; i >= 0; i = i - 1)
		begin
			lvl = {hi[i], lo[i]}; // RULE1
			if (req[i] && (!ivc_resolve[6] || lvl >= ivc_resolve[5:4])) // RULE4
				ivc_resolve = {1'b1, lvl, i[3:0]};
		end
	end
endfunction

// returns {any, level} of the highest in-service marker
function [2:0] ivc_top;
	input [3:0] m;
	begin
		ivc_top = {|m, m[3] | m[2], m[3] | (~m[2] & m[1])};
	end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [11:0] enable_reg;
reg [10:0] prio_low_bits_reg;
reg [10:0] prio_high_bits_reg;
reg [3:0] ext_trigger_type_reg;
reg [3:0] ext_edge_flag_reg;
reg [3:0] ext_samp_reg;
reg tmr0_ovf_flag_reg;
reg tmr1_ovf_flag_reg;
reg [3:0] isv_reg;
reg [1:0] state_reg;
reg [3:0] win_idx_reg;
reg [1:0] state_next;
reg [3:0] isv_next;
reg [3:0] isv_clr;

wire [3:0] ext_pin_n;
wire [3:0] ext_irq_flag;
wire [10:0] src_flag, src_req, vec_hit;
wire [6:0] win;
wire [2:0] cur;
wire preempt_ok, accept, wr_en, rd_setup, wr_flags;

// ----------------------------------------------------------------
// external pin synchroniser
// ----------------------------------------------------------------
ivc_pin_sync #(.W(4), .RST_VAL(`IVC_RST_PIN)) u_pin_sync
(
	.pclk(pclk),
	.presetn(presetn),
	.pin_in(ext_irq_pin_n),
	.pin_out(ext_pin_n)
);

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
assign pready = 1'b1; // zero wait states
assign wr_en = psel & penable & pwrite;
assign rd_setup = psel & ~penable;
assign wr_flags = wr_en && (paddr == `IVC_OFF_FLAGS);

// ----------------------------------------------------------------
// source flag assembly
// ----------------------------------------------------------------
genvar g;
generate
	for (g = 0; g <= `IVC_EXT_MSB; g = g + 1)
	begin : g_ext
		// flag bit sits at the source's natural-order position
		localparam integer SRC = (g == 0) ? `IVC_SRC_EXT0 : (g == 1) ? `IVC_SRC_EXT1 :
			(g == 2) ? `IVC_SRC_EXT2 : `IVC_SRC_EXT3;
		// level mode follows the inverted pin, software cannot touch it
		assign ext_irq_flag[g] = ext_trigger_type_reg[g] ? ext_edge_flag_reg[g] : ~ext_pin_n[g]; // RULE7

		// edge flag: set beats clear so a fresh edge is never lost
		always @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				ext_edge_flag_reg[g] <= 1'b0;
				ext_samp_reg[g] <= 1'b1;
			end
			else
			begin
				if (mc_strobe)
					ext_samp_reg[g] <= ext_pin_n[g]; // RULE9
				if (mc_strobe && ext_samp_reg[g] && !ext_pin_n[g])
					ext_edge_flag_reg[g] <= 1'b1; // RULE19
				else if (wr_flags && ext_trigger_type_reg[g])
					ext_edge_flag_reg[g] <= pwdata[SRC]; // RULE18
				else if (vec_hit[SRC])
					ext_edge_flag_reg[g] <= 1'b0; // RULE7
			end
		end
	end
endgenerate

// shared vectors request on the or of their flags
assign src_flag[`IVC_SRC_EXT0] = ext_irq_flag[0];
assign src_flag[`IVC_SRC_TMR0] = tmr0_ovf_flag_reg;
assign src_flag[`IVC_SRC_EXT1] = ext_irq_flag[1];
assign src_flag[`IVC_SRC_TMR1] = tmr1_ovf_flag_reg;
assign src_flag[`IVC_SRC_UART] = uart_rx_flag | uart_tx_flag; // RULE17
assign src_flag[`IVC_SRC_TMR2] = tmr2_ovf_flag | tmr2_ext_flag; // RULE17
assign src_flag[`IVC_SRC_EXT2] = ext_irq_flag[2];
assign src_flag[`IVC_SRC_EXT3] = ext_irq_flag[3];
assign src_flag[`IVC_SRC_SPI] = spi_done_flag | spi_fault_flag | spi_overrun_flag; // RULE17
assign src_flag[`IVC_SRC_WAKE] = wake_timer_flag;
assign src_flag[`IVC_SRC_BOD] = brownout_flag;

// ----------------------------------------------------------------
// poll and resolve, purely from present flags
// ----------------------------------------------------------------
// nothing latches a request, so a blocked one vanishes with its flag
assign src_req = src_flag & enable_reg[`IVC_SRC_MSB:0] & {11{enable_reg[`IVC_GIE_BIT]}}; // RULE16 RULE18 RULE11
assign win = ivc_resolve(src_req, prio_high_bits_reg, prio_low_bits_reg); // RULE9
assign cur = ivc_top(isv_reg);
// level three in service leaves nothing strictly higher
assign preempt_ok = !cur[2] || (win[5:4] > cur[1:0]); // RULE2 RULE3
assign accept = mc_strobe && (state_reg == `IVC_ST_IDLE) && win[6] && preempt_ok &&
	insn_last_cycle && !insn_blocks_irq; // RULE10 RULE15
assign vec_hit = accept ? (11'h001 << win[3:0]) : 11'h000;

// ----------------------------------------------------------------
// timer 0/1 flags; timer 2 flags stay with the timer
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		tmr0_ovf_flag_reg <= 1'b0;
		tmr1_ovf_flag_reg <= 1'b0;
	end
	else
	begin
		if (tmr0_ovf_set)
			tmr0_ovf_flag_reg <= 1'b1;
		else if (wr_flags)
			tmr0_ovf_flag_reg <= pwdata[`IVC_SRC_TMR0];
		else if (vec_hit[`IVC_SRC_TMR0])
			tmr0_ovf_flag_reg <= 1'b0; // RULE8
		if (tmr1_ovf_set)
			tmr1_ovf_flag_reg <= 1'b1;
		else if (wr_flags)
			tmr1_ovf_flag_reg <= pwdata[`IVC_SRC_TMR1];
		else if (vec_hit[`IVC_SRC_TMR1])
			tmr1_ovf_flag_reg <= 1'b0; // RULE8
	end
end

// ----------------------------------------------------------------
// in-service markers and call sequencer
// ----------------------------------------------------------------
always @*
begin
	// only the true return ends service; a plain return never reaches here
	isv_clr = 4'h0;
	if (irq_return && cur[2])
		isv_clr = 4'h1 << cur[1:0]; // RULE13 RULE20
	isv_next = isv_reg & ~isv_clr;
	if (accept)
		isv_next = isv_next | (4'h1 << win[5:4]); // RULE20
	state_next = state_reg;
	case (state_reg)
		`IVC_ST_IDLE:
			if (accept)
				state_next = `IVC_ST_PUSH;
		`IVC_ST_PUSH:
			if (mc_strobe)
				state_next = `IVC_ST_LOAD; // RULE14
		`IVC_ST_LOAD:
			if (mc_strobe)
				state_next = `IVC_ST_IDLE; // RULE14
		default:
			state_next = `IVC_ST_IDLE;
	endcase
end

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		isv_reg <= 4'h0;
		state_reg <= `IVC_ST_IDLE;
		win_idx_reg <= 4'h0;
		vec_addr <= 16'h0000;
		call_active <= 1'b0;
		call_push_pc <= 1'b0;
		call_load_pc <= 1'b0;
		wake_req <= 1'b0;
	end
	else
	begin
		isv_reg <= isv_next;
		state_reg <= state_next;
		if (accept)
		begin
			win_idx_reg <= win[3:0];
			vec_addr <= `IVC_VEC_BASE + {9'h000, win[3:0], 3'h0}; // RULE5
		end
		// push covers the first machine cycle, load the second; no status word
		call_active <= (state_next != `IVC_ST_IDLE); // RULE14
		call_push_pc <= (state_next == `IVC_ST_PUSH); // RULE12
		call_load_pc <= (state_next == `IVC_ST_LOAD); // RULE12
		wake_req <= |(src_req & `IVC_WAKE_MASK); // RULE6
	end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		enable_reg <= `IVC_RST_ENABLE;
		prio_low_bits_reg <= `IVC_RST_PRIO;
		prio_high_bits_reg <= `IVC_RST_PRIO;
		ext_trigger_type_reg <= `IVC_RST_TRIG;
	end
	else if (wr_en)
	begin
		case (paddr)
			`IVC_OFF_ENABLE: enable_reg <= pwdata[11:0];
			`IVC_OFF_PRIO_LO: prio_low_bits_reg <= pwdata[10:0]; // RULE1
			`IVC_OFF_PRIO_HI: prio_high_bits_reg <= pwdata[10:0]; // RULE1
			`IVC_OFF_TRIG: ext_trigger_type_reg <= pwdata[3:0];
			default: enable_reg <= enable_reg;
		endcase
	end
end

// read data captured in setup, so it stands through the access phase
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else if (rd_setup)
	begin
		pslverr <= 1'b0;
		case (paddr)
			`IVC_OFF_ENABLE: prdata <= {20'h0, enable_reg};
			`IVC_OFF_PRIO_LO: prdata <= {21'h0, prio_low_bits_reg};
			`IVC_OFF_PRIO_HI: prdata <= {21'h0, prio_high_bits_reg};
			`IVC_OFF_TRIG: prdata <= {28'h0, ext_trigger_type_reg};
			`IVC_OFF_FLAGS: prdata <= {21'h0, src_flag};
			`IVC_OFF_STATUS: prdata <= {19'h0, wake_req, win_idx_reg, call_active, cur, isv_reg};
			default:
			begin
				prdata <= 32'h00000000;
				pslverr <= 1'b1; // unmapped offset
			end
		endcase
	end
end

endmodule

// ===== hw/ivc_consts.vh
// constants of the four-level vectored interrupt controller
// assumes: included by bare name from design files, plain verilog-2005
`ifndef IVC_CONSTS_VH
`define IVC_CONSTS_VH

// ----------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------
`define IVC_OFF_ENABLE 8'h00
`define IVC_OFF_PRIO_LO 8'h04
`define IVC_OFF_PRIO_HI 8'h08
`define IVC_OFF_TRIG 8'h0c
`define IVC_OFF_FLAGS 8'h10
`define IVC_OFF_STATUS 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IVC_GIE_BIT 11
`define IVC_SRC_MSB 10
`define IVC_EXT_MSB 3

// ----------------------------------------------------------------
// source indices in natural order (0 wins ties)
// ----------------------------------------------------------------
`define IVC_SRC_EXT0 0
`define IVC_SRC_TMR0 1
`define IVC_SRC_EXT1 2
`define IVC_SRC_TMR1 3
`define IVC_SRC_UART 4
`define IVC_SRC_TMR2 5
`define IVC_SRC_EXT2 6
`define IVC_SRC_EXT3 7
`define IVC_SRC_SPI 8
`define IVC_SRC_WAKE 9
`define IVC_SRC_BOD 10

// ----------------------------------------------------------------
// vectors, wake mask, reset values
// ----------------------------------------------------------------
`define IVC_VEC_BASE 16'h0003
`define IVC_WAKE_MASK 11'h6c5
`define IVC_RST_ENABLE 12'h000
`define IVC_RST_PRIO 11'h000
`define IVC_RST_TRIG 4'h0
`define IVC_RST_PIN 4'hf

// ----------------------------------------------------------------
// vector call states: idle, then one per machine cycle of the call
// ----------------------------------------------------------------
`define IVC_ST_IDLE 2'h0
`define IVC_ST_PUSH 2'h1
`define IVC_ST_LOAD 2'h2

`endif

// ===== hw/ivc_pin_sync.v
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes: pins are asynchronous to pclk and held for a machine cycle
`timescale 1ns/1ps

module ivc_pin_sync #(
	parameter W = 4,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
)
(
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] pin_in,
	output wire [W-1:0] pin_out
);

reg [W-1:0] s1_reg;
reg [W-1:0] s2_reg;
reg [W-1:0] s3_reg;
reg [W-1:0] stable_reg;

// ----------------------------------------------------------------
// chain; first stage only feeds the second
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		s1_reg <= RST_VAL;
		s2_reg <= RST_VAL;
		s3_reg <= RST_VAL;
		stable_reg <= RST_VAL;
	end
	else
	begin
		s1_reg <= pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		// a bit changes only once stages two and three agree
		stable_reg <= (s2_reg & s3_reg) | (stable_reg & (s2_reg ^ s3_reg));
	end
end

assign pin_out = stable_reg;

endmodule

// ===== verif/ivc_core_sva.sv
// concurrent checks on the controller ports
// assumes: single pclk domain, presetn asynchronous active low
`timescale 1ns/1ps

module ivc_core_sva
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire mc_strobe,
	input wire insn_last_cycle,
	input wire insn_blocks_irq,
	input wire call_active,
	input wire call_push_pc,
	input wire call_load_pc,
	input wire [15:0] vec_addr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// --------------------------------
	// hardware call, one phase per machine cycle
	// --------------------------------
	call_start_a: assert property ($rose(call_active) |-> call_push_pc && !call_load_pc)
		else $error("call opened without push phase");
	push_to_load_a: assert property (call_push_pc && mc_strobe |=> call_load_pc && !call_push_pc)
		else $error("push phase not followed by load");
	push_hold_a: assert property (call_push_pc && !mc_strobe |=> call_push_pc)
		else $error("push phase ended early");
	load_end_a: assert property (call_load_pc && mc_strobe |=> !call_active)
		else $error("call longer than two cycles");
	one_phase_a: assert property (call_active |-> call_push_pc != call_load_pc)
		else $error("call phases overlap");
	accept_cond_a: assert property ($rose(call_active) |-> $past(mc_strobe && insn_last_cycle && !insn_blocks_irq))
		else $error("call taken outside allowed poll");
	vec_form_a: assert property ($rose(call_active) |-> vec_addr[2:0] == 3'h3 && vec_addr <= 16'h0053)
		else $error("vector off the table");
	vec_hold_a: assert property (call_active && $past(call_active) |-> $stable(vec_addr))
		else $error("vector moved during call");
	// --------------------------------
	// register port
	// --------------------------------
	err_bad_a: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("unmapped access not flagged");
	err_ok_a: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr && pready)
		else $error("mapped access flagged");
endmodule

bind ivc_core ivc_core_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .mc_strobe(mc_strobe),
	.insn_last_cycle(insn_last_cycle), .insn_blocks_irq(insn_blocks_irq), .call_active(call_active),
	.call_push_pc(call_push_pc), .call_load_pc(call_load_pc), .vec_addr(vec_addr));

// ===== verif/ivc_core_model.sv
// processor core sequencer model: machine cycles, last cycle, blocking
// assumes: bench requests returns and blocking windows
`timescale 1ns/1ps

module ivc_core_model
(
	input wire pclk,
	input wire presetn,
	input wire blk,
	input wire ret_req,
	output wire mc_strobe,
	output wire insn_last_cycle,
	output wire insn_blocks_irq,
	output reg irq_return
);
	reg [1:0] cnt_reg;
	reg odd_reg;
	reg pend_reg;
	// --------------------------------
	// four pclk per machine cycle, two-cycle instructions
	// --------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 2'h0;
			odd_reg <= 1'b0;
			pend_reg <= 1'b0;
			irq_return <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_reg + 2'h1;
			if (cnt_reg == 2'h3)
				odd_reg <= ~odd_reg;
			// return lands on the strobe cycle, ending its instruction
			irq_return <= pend_reg && cnt_reg == 2'h2;
			if (ret_req)
				pend_reg <= 1'b1;
			else if (cnt_reg == 2'h2)
				pend_reg <= 1'b0;
		end
	end
	assign mc_strobe = cnt_reg == 2'h3;
	assign insn_last_cycle = ~odd_reg;
	assign insn_blocks_irq = blk | irq_return;
endmodule

// ===== verif/testbench.sv
// self-checking bench for the vectored interrupt controller
// assumes: core model paces machine cycles, bench drives apb and flags
`timescale 1ns/1ps
`include "ivc_consts.vh"

module testbench;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] pin_n = 4'hf;
	reg [10:0] src = 11'h000;
	reg t0_set = 1'b0;
	reg [3:0] shr = 4'h0;
	reg blk = 1'b0;
	reg ret_req = 1'b0;
	reg [31:0] rd;
	reg err;
	wire [31:0] prdata;
	wire [15:0] vec_addr;
	wire pready, pslverr, mc_strobe, ilc, ibi, irq_ret, call_active, wake_req;
	integer num_errors = 0;
	integer compares = 0;
	integer cyc = 0;
	integer i;
	integer ord [0:4] = '{4, 5, 8, 9, 10};

	// --------------------------------
	// clock, core model, design
	// --------------------------------
	always #12.5 pclk = ~pclk;

	ivc_core_model u_core (.pclk(pclk), .presetn(presetn), .blk(blk), .ret_req(ret_req),
		.mc_strobe(mc_strobe), .insn_last_cycle(ilc), .insn_blocks_irq(ibi), .irq_return(irq_ret));

	ivc_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_irq_pin_n(pin_n), .tmr0_ovf_set(t0_set), .tmr1_ovf_set(t0_set), .tmr2_ovf_flag(src[5]),
		.tmr2_ext_flag(shr[1]), .uart_rx_flag(src[4]), .uart_tx_flag(shr[0]), .spi_done_flag(src[8]),
		.spi_fault_flag(shr[2]), .spi_overrun_flag(shr[3]), .wake_timer_flag(src[9]), .brownout_flag(src[10]),
		.mc_strobe(mc_strobe), .insn_last_cycle(ilc), .insn_blocks_irq(ibi), .irq_return(irq_ret),
		.call_active(call_active), .call_push_pc(), .call_load_pc(), .vec_addr(vec_addr), .wake_req(wake_req));

	// --------------------------------
	// tasks
	// --------------------------------
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		compares = compares + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// setup then access; hold until pready sampled high
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd_chk(input string nm, input [7:0] a, input [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	task wait_call(input [15:0] v);
		repeat (200)
			if (call_active !== 1'b1)
				@(negedge pclk);
		chk("call", {31'h0, call_active}, 32'h1);
		chk("vector", {16'h0, vec_addr}, {16'h0, v});
		while (call_active === 1'b1)
			@(negedge pclk);
	endtask

	task nocall(input integer n);
		reg s;
		s = 1'b0;
		repeat (n)
		begin
			@(negedge pclk);
			s = s | call_active;
		end
		chk("no call", {31'h0, s}, 32'h0);
	endtask

	// return is issued by the core model at its next strobe, or the one after when ret_req is sampled while cnt_reg is 2
	task ret;
		@(posedge pclk);
		ret_req <= 1'b1;
		@(posedge pclk);
		ret_req <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask

	task report_and_stop;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, far beyond the roughly one thousand cycles needed
	always @(posedge pclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			num_errors = num_errors + 1;
			report_and_stop;
		end
	end

	// --------------------------------
	// test sequence
	// --------------------------------
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("enable", `IVC_OFF_ENABLE, 32'h0);
		rd_chk("prio", `IVC_OFF_PRIO_LO, 32'h0);
		rd_chk("status", `IVC_OFF_STATUS, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped", {31'h0, err}, 32'h1);
		apb(1'b1, `IVC_OFF_ENABLE, 32'h00000fff);
		apb(1'b1, `IVC_OFF_TRIG, 32'h00000001);
		$display("test registers done");
		src <= 11'h010;
		repeat (4) @(negedge pclk);
		chk("wake", {31'h0, wake_req}, 32'h0);
		@(posedge pclk);
		src <= 11'h730;
		repeat (4) @(negedge pclk);
		chk("wake", {31'h0, wake_req}, 32'h1);
		for (i = 0; i < 5; i = i + 1)
		begin
			wait_call(16'h0003 + 16'h0008 * ord[i]);
			nocall(40);
			@(posedge pclk);
			src[ord[i]] <= 1'b0;
			ret;
		end
		$display("test natural order done");
		apb(1'b1, `IVC_OFF_PRIO_LO, 32'h00000410);
		apb(1'b1, `IVC_OFF_PRIO_HI, 32'h00000500);
		src <= 11'h420;
		wait_call(16'h0053);
		@(posedge pclk);
		src <= 11'h120;
		nocall(80);
		ret;
		wait_call(16'h0043);
		@(posedge pclk);
		src <= 11'h020;
		ret;
		wait_call(16'h002b);
		@(posedge pclk);
		src <= 11'h030;
		wait_call(16'h0023);
		rd_chk("markers", `IVC_OFF_STATUS, 32'h00000453);
		src <= 11'h000;
		ret;
		ret;
		rd_chk("markers", `IVC_OFF_STATUS, 32'h00000400);
		$display("test levels done");
		blk <= 1'b1;
		pin_n <= 4'he;
		src <= 11'h010;
		nocall(80);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h00000011);
		src <= 11'h000;
		pin_n <= 4'hf;
		blk <= 1'b0;
		wait_call(16'h0003);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h0);
		ret;
		t0_set <= 1'b1;
		@(posedge pclk);
		t0_set <= 1'b0;
		wait_call(16'h000b);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h00000008);
		ret;
		wait_call(16'h001b);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h0);
		ret;
		pin_n <= 4'hd;
		wait_call(16'h0013);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h00000004);
		pin_n <= 4'hf;
		ret;
		// the non-first flags of each shared vector raise the request without the first
		shr <= 4'hf;
		wait_call(16'h0043);
		rd_chk("flags", `IVC_OFF_FLAGS, 32'h00000130);
		shr <= 4'h0;
		ret;
		$display("test flags done");
		report_and_stop;
	end
endmodule
